//--- design/mpc_pkg.sv
package mpc_pkg;
	// ------------------------------------------------------------
	// widths and timing
	// ------------------------------------------------------------
	localparam int unsigned MCLK_HZ       = 200_000_000;
	localparam int unsigned FAST_OSC_HZ   = 10_000_000;
	localparam int unsigned SLOW_OSC_HZ   = 32_000;
	// half period, rounded down so the nominal rate is never undershot
	localparam int unsigned FAST_HALF_CYC = MCLK_HZ / (2 * FAST_OSC_HZ);
	localparam int unsigned SLOW_HALF_CYC = MCLK_HZ / (2 * SLOW_OSC_HZ);
	localparam int unsigned INT_MULT_W    = 7;
	localparam int unsigned FRAC_MULT_W   = 2;
	localparam logic [6:0]  INT_MULT_BYPASS = 7'h00;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [INT_MULT_W-1:0]  pll_int_mult;
		logic [FRAC_MULT_W-1:0] pll_frac_mult;
	} mpc_mult_t;

	typedef struct packed {
		logic fast_internal_osc_clock;
		logic slow_internal_osc_clock;
	} mpc_osc_clks_t;
endpackage : mpc_pkg

//--- design/mpc_main_pll.sv
`timescale 1ns/1ps
// Behaviour
// R1 - pll reference comes from the primary clock pin, oscillator or crystal
// R2 - pll multiplies reference by integer plus fractional factor
// R3 - software keeps raw pll output between 150 and 300 MHz
// R4 - raw pll output is halved before the clock-select mux
// R5 - integer field zero makes the mux pass the reference clock (bypass)
// R6 - nonzero integer code N multiplies by N
// R7 - mux output passes a programmable divider to form the system clock
// R8 - internal oscillator gives fixed fast and slow clocks, not configurable
// R9 - internal clocks go to low-power logic, fast one to missing-clock detect
// R10 - aux clock input feeds only usb pll and can; others use primary clock
// R11 - software should not run the device from internal oscillator clocks
// R12 - in bypass the fractional setting has no effect
module mpc_main_pll #(
	parameter int unsigned PER_W = 16,
	parameter int unsigned DIV_W = 6
) (
	input  wire logic                 mclk_in,
	input  wire logic                 resetn_in,
	input  wire logic                 ce_in,
	input  wire logic                 primary_clock_pin_in,
	input  wire logic                 aux_clock_input_in,
	input  wire mpc_pkg::mpc_mult_t   pll_mult_reg_in,
	input  wire logic [DIV_W-1:0]     sys_clk_div_sel_in,
	output logic                      pll_system_clock_out,
	output logic                      pll_raw_clock_out,
	output logic                      pll_bypass_out,
	output mpc_pkg::mpc_osc_clks_t    lpm_osc_clks_out,
	output logic                      mcd_clock_out,
	output logic                      usb_pll_ref_out,
	output logic                      can_clock_out
);
	localparam int unsigned ACC_W = PER_W + 2;
	localparam int unsigned MUL_W = mpc_pkg::INT_MULT_W + mpc_pkg::FRAC_MULT_W;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	// only the second flop feeds logic; the first may still be settling
	logic ref_s1_q, ref_s2_q, ref_prev_q, aux_s1_q, aux_s2_q;

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ref_s1_q   <= 1'b0;
			ref_s2_q   <= 1'b0;
			ref_prev_q <= 1'b0;
			aux_s1_q   <= 1'b0;
			aux_s2_q   <= 1'b0;
		end else if (ce_in) begin
			ref_s1_q   <= primary_clock_pin_in; // [R1]
			ref_s2_q   <= ref_s1_q;
			ref_prev_q <= ref_s2_q;
			aux_s1_q   <= aux_clock_input_in;
			aux_s2_q   <= aux_s1_q;
		end
	end

	wire logic ref_rise = ref_s2_q & ~ref_prev_q;

	// aux clock reaches only usb pll and can
	assign usb_pll_ref_out = aux_s2_q; // [R10]
	assign can_clock_out   = aux_s2_q; // [R10]

	// ------------------------------------------------------------
	// reference period measurement
	// ------------------------------------------------------------
	logic [PER_W-1:0] per_cnt_q, per_cnt_d, per_q, per_d;

	always_comb begin
		per_cnt_d = per_cnt_q;
		per_d     = per_q;
		if (ref_rise) begin
			// a stalled reference must not wrap to zero and read as no period
			per_d     = (per_cnt_q == '1) ? per_cnt_q : per_cnt_q + PER_W'(1);
			per_cnt_d = '0;
		end else if (per_cnt_q != '1) begin
			per_cnt_d = per_cnt_q + PER_W'(1);
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			per_cnt_q <= '0;
			per_q     <= '0;
		end else if (ce_in) begin
			per_cnt_q <= per_cnt_d;
			per_q     <= per_d;
		end
	end

	// ------------------------------------------------------------
	// synthesiser: raw clock at ref * (int + frac/4)
	// ------------------------------------------------------------
	// rate is bounded by mclk; faster settings saturate at one toggle a cycle
	logic [ACC_W-1:0] acc_q, acc_d, acc_sum, acc_lim;
	logic [MUL_W-1:0] mult_q4;
	logic             bypass, tick;
	logic             raw_q, raw_d, half_q, half_d;

	always_comb begin
		bypass  = (pll_mult_reg_in.pll_int_mult == mpc_pkg::INT_MULT_BYPASS); // [R5]
		// quarter units: integer code N is plain binary xN
		mult_q4 = {pll_mult_reg_in.pll_int_mult, pll_mult_reg_in.pll_frac_mult}; // [R2] [R6]
		acc_lim = {1'b0, per_q, 1'b0};
		acc_sum = acc_q + ACC_W'(mult_q4);
		tick    = 1'b0;
		acc_d   = acc_sum;
		raw_d   = raw_q;
		half_d  = half_q;
		if (bypass || per_q == '0) begin
			// frac field is ignored while bypassed
			acc_d = '0; // [R12]
		end else if (acc_sum >= acc_lim) begin
			acc_d = acc_sum - acc_lim;
			tick  = 1'b1;
		end
		if (tick) begin
			raw_d = ~raw_q;
			if (!raw_q) begin
				half_d = ~half_q; // [R4]
			end
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			acc_q  <= '0;
			raw_q  <= 1'b0;
			half_q <= 1'b0;
		end else if (ce_in) begin
			acc_q  <= acc_d;
			raw_q  <= raw_d;
			half_q <= half_d;
		end
	end

	assign pll_raw_clock_out = raw_q;

	// ------------------------------------------------------------
	// clock-select mux and system divider
	// ------------------------------------------------------------
	// select 0 passes the mux clock, n divides by 2n
	// a select change mid-count may stretch one output period
	logic             mux_clk, mux_prev_q, sys_q, sys_d, byp_q;
	logic [DIV_W-1:0] div_cnt_q, div_cnt_d;

	always_comb begin
		mux_clk   = bypass ? ref_s2_q : half_q; // [R5] [R12]
		sys_d     = sys_q;
		div_cnt_d = div_cnt_q;
		if (sys_clk_div_sel_in == '0) begin
			sys_d     = mux_clk; // [R7]
			div_cnt_d = '0;
		end else if (mux_clk && !mux_prev_q) begin
			if (div_cnt_q >= sys_clk_div_sel_in - DIV_W'(1)) begin
				div_cnt_d = '0;
				sys_d     = ~sys_q; // [R7]
			end else begin
				div_cnt_d = div_cnt_q + DIV_W'(1);
			end
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			mux_prev_q <= 1'b0;
			sys_q      <= 1'b0;
			div_cnt_q  <= '0;
			byp_q      <= 1'b1;
		end else if (ce_in) begin
			mux_prev_q <= mux_clk;
			sys_q      <= sys_d;
			div_cnt_q  <= div_cnt_d;
			byp_q      <= bypass;
		end
	end

	assign pll_system_clock_out = sys_q;
	assign pll_bypass_out       = byp_q;

	// ------------------------------------------------------------
	// internal zero-pin oscillator
	// ------------------------------------------------------------
	// fixed dividers with no config inputs, so nothing can retune them
	logic [11:0] fast_cnt_q, fast_cnt_d, slow_cnt_q, slow_cnt_d;
	logic        fast_q, fast_d, slow_q, slow_d;

	always_comb begin
		fast_cnt_d = fast_cnt_q + 12'h001;
		fast_d     = fast_q;
		slow_cnt_d = slow_cnt_q + 12'h001;
		slow_d     = slow_q;
		if (fast_cnt_q == 12'(mpc_pkg::FAST_HALF_CYC - 1)) begin
			fast_cnt_d = 12'h000;
			fast_d     = ~fast_q; // [R8]
		end
		if (slow_cnt_q == 12'(mpc_pkg::SLOW_HALF_CYC - 1)) begin
			slow_cnt_d = 12'h000;
			slow_d     = ~slow_q; // [R8]
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			fast_cnt_q <= 12'h000;
			fast_q     <= 1'b0;
			slow_cnt_q <= 12'h000;
			slow_q     <= 1'b0;
		end else if (ce_in) begin
			fast_cnt_q <= fast_cnt_d;
			fast_q     <= fast_d;
			slow_cnt_q <= slow_cnt_d;
			slow_q     <= slow_d;
		end
	end

	assign lpm_osc_clks_out.fast_internal_osc_clock = fast_q; // [R9]
	assign lpm_osc_clks_out.slow_internal_osc_clock = slow_q; // [R9]
	assign mcd_clock_out                            = fast_q; // [R9]
endmodule : mpc_main_pll

//--- testbench/mpc_main_pll_asserts.sv
`timescale 1ns/1ps
module mpc_main_pll_asserts #(
	parameter int unsigned DIV_W = 6
) (
	input wire logic                   mclk_in,
	input wire logic                   resetn_in,
	input wire logic                   ce_in,
	input wire logic                   primary_clock_pin_in,
	input wire logic                   aux_clock_input_in,
	input wire mpc_pkg::mpc_mult_t     pll_mult_reg_in,
	input wire logic [DIV_W-1:0]       sys_clk_div_sel_in,
	input wire logic                   pll_system_clock_out,
	input wire logic                   pll_raw_clock_out,
	input wire logic                   pll_bypass_out,
	input wire mpc_pkg::mpc_osc_clks_t lpm_osc_clks_out,
	input wire logic                   mcd_clock_out,
	input wire logic                   can_clock_out,
	input wire logic                   usb_pll_ref_out
);
	// ----
	// slow osc period counter, clock-enable guard
	// ----
	logic        fst, slw, tgl, seen_q, seen_d, prev_q, prev_d;
	logic [11:0] cnt_q, cnt_d;
	logic [3:0]  run_q, run_d;
	default clocking cb @(posedge mclk_in); endclocking
	// $past reaches back 3 cycles, so checks wait for 4 enabled cycles
	default disable iff (!resetn_in || run_q < 4'h4);
	assign fst = lpm_osc_clks_out.fast_internal_osc_clock;
	assign slw = lpm_osc_clks_out.slow_internal_osc_clock;
	always_comb begin
		tgl    = slw != prev_q;
		prev_d = slw;
		cnt_d  = tgl ? 12'h000 : cnt_q + 12'h001;
		// a freeze stretches one slow period, so skip its next check
		seen_d = ce_in ? (seen_q | tgl) : 1'b0;
		run_d  = !ce_in ? 4'h0 : ((run_q == 4'hf) ? run_q : run_q + 4'h1);
	end
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			prev_q <= 1'b0;
			cnt_q  <= 12'h000;
			seen_q <= 1'b0;
			run_q  <= 4'h0;
		end else begin
			prev_q <= prev_d;
			cnt_q  <= cnt_d;
			seen_q <= seen_d;
			run_q  <= run_d;
		end
	end
	AST_BYP_SET: assert property (pll_mult_reg_in.pll_int_mult == 7'h00 |=> pll_bypass_out)
		else $error("bypass flag missing");
	AST_BYP_CLR: assert property (pll_mult_reg_in.pll_int_mult != 7'h00 |=> !pll_bypass_out)
		else $error("bypass flag stuck");
	AST_BYP_PATH: assert property (pll_bypass_out && $past(pll_bypass_out, 3)
		&& sys_clk_div_sel_in == '0 |-> pll_system_clock_out == $past(primary_clock_pin_in, 3))
		else $error("bypass clock not the reference");
	AST_RAW_QUIET: assert property (pll_bypass_out && $past(pll_bypass_out)
		|-> $stable(pll_raw_clock_out)) else $error("raw clock runs in bypass");
	AST_FAST_PER: assert property ($changed(fst) |=> $stable(fst)[*8] ##1 $stable(fst)
		##1 $changed(fst)) else $error("fast osc period wrong");
	AST_MCD_PER: assert property ($changed(mcd_clock_out) |=> $stable(mcd_clock_out)[*8]
		##1 $stable(mcd_clock_out) ##1 $changed(mcd_clock_out)) else $error("mcd period wrong");
	AST_SLOW_PER: assert property (tgl && seen_q |-> cnt_q == 12'hc34)
		else $error("slow osc period wrong");
	AST_AUX_PAIR: assert property (usb_pll_ref_out == $past(aux_clock_input_in, 2)
		&& can_clock_out == usb_pll_ref_out) else $error("usb and can clocks not the aux input");
	AST_AUX_SRC: assert property ($rose(can_clock_out) |-> $past(aux_clock_input_in, 2))
		else $error("can clock not from aux input");
endmodule : mpc_main_pll_asserts
bind mpc_main_pll mpc_main_pll_asserts #(.DIV_W(DIV_W)) u_chk (.*);

//--- testbench/mpc_main_pll_tb.sv
`timescale 1ns/1ps
module mpc_main_pll_tb;
	logic                   mclk_in = 1'b0, resetn_in = 1'b0, ref_q = 1'b0, aux_q = 1'b0;
	logic                   ce = 1'b1;
	mpc_pkg::mpc_mult_t     mult = '0;
	logic [5:0]             sel = 6'h00;
	logic                   sys, raw, byp, mcd, usb, can;
	mpc_pkg::mpc_osc_clks_t osc;
	int                     errors = 0, total_checks = 0, cyc = 0, n [6];
	// raw rate 15-30 mhz on a 2.5 mhz ref: the 150-300 band scaled 1/10
	int                     ti [5] = '{6, 8, 7, 12, 10}, tf [5] = '{0, 3, 2, 0, 1};
	int                     ts [5] = '{0, 1, 0, 2, 3};
	mpc_main_pll DUT (.mclk_in(mclk_in), .resetn_in(resetn_in), .ce_in(ce),
		.primary_clock_pin_in(ref_q), .aux_clock_input_in(aux_q), .pll_mult_reg_in(mult),
		.sys_clk_div_sel_in(sel), .pll_system_clock_out(sys), .pll_raw_clock_out(raw),
		.pll_bypass_out(byp), .lpm_osc_clks_out(osc), .mcd_clock_out(mcd),
		.usb_pll_ref_out(usb), .can_clock_out(can));
	// ----
	// clocks, reference pins, timeout
	// ----
	initial forever #2.5 mclk_in = ~mclk_in;
	always @(posedge mclk_in) begin
		cyc <= cyc + 1;
		// 2.5 mhz reference; aux levels last 8 cycles, well past the synchroniser
		if (resetn_in && cyc % 40 == 0) ref_q <= #1 ~ref_q;
		if (resetn_in && cyc % 8 == 0) aux_q <= #1 ~aux_q;
		if (cyc == 30000) begin
			errors = errors + 1;
			finish_test();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// edge counts jitter by phase, so allow a few
	function automatic int near(input int s, input int e);
		return (s - e <= 3 && e - s <= 3) ? e : s;
	endfunction : near
	task automatic cfg(input logic [6:0] i, input logic [1:0] f, input logic [5:0] s);
		mult = {i, f};
		sel = s; // operating clock is the pll path or the bypassed reference, never the internal osc
		repeat (200) @(posedge mclk_in);
		#1;
	endtask : cfg
	task automatic measure;
		logic [5:0] p, c;
		n = '{default: 0};
		p = {raw, sys, osc.fast_internal_osc_clock, mcd, usb, can};
		repeat (2000) begin
			@(posedge mclk_in);
			#1;
			c = {raw, sys, osc.fast_internal_osc_clock, mcd, usb, can};
			for (int b = 0; b < 6; b++) n[b] += int'(c[b] ^ p[b]);
			p = c;
		end
	endtask : measure
	// ----
	// scenarios
	// ----
	task automatic t_bypass;
		cfg(7'h00, 2'h3, 6'h00);
		measure();
		chk(byp, 1'b1);
		chk(n[5], 0);
		chk(near(n[4], 50), 50);
	endtask : t_bypass
	task automatic t_mult;
		int r, s;
		for (int k = 0; k < 5; k++) begin
			cfg(ti[k][6:0], tf[k][1:0], ts[k][5:0]);
			measure();
			r = 25 * (4 * ti[k] + tf[k]) / 2;
			s = r / 2 / (ts[k] == 0 ? 1 : 2 * ts[k]);
			chk(byp, 1'b0);
			chk(near(n[5], r), r);
			chk(near(n[4], s), s);
		end
	endtask : t_mult
	task automatic t_ce;
		logic [7:0] s;
		s = {raw, sys, byp, osc, mcd, usb, can};
		ce = 1'b0;
		repeat (45) @(posedge mclk_in);
		#1;
		chk({raw, sys, byp}, s[7:5]);
		chk({osc, mcd, usb, can}, s[4:0]);
		ce = 1'b1;
		repeat (20) @(posedge mclk_in);
		#1;
	endtask : t_ce
	task automatic t_osc;
		measure();
		chk(near(n[3], 200), 200);
		chk(near(n[2], 200), 200);
		chk(near(n[1], 250), 250);
		chk(near(n[0], 250), 250);
	endtask : t_osc
	task automatic finish_test;
		$display("errors=%0d total_checks=%0d", errors, total_checks);
		if (errors == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : finish_test
	initial begin
		repeat (6) @(posedge mclk_in);
		#1 resetn_in = 1'b1;
		t_bypass();
		t_mult();
		t_ce();
		t_osc();
		finish_test();
	end
endmodule : mpc_main_pll_tb
